// >>> igsr_params.svh
// Constants for the ion gauge setpoint relay control block
//
// Function
// - Degas runs for programmed minutes, 2 to 10, default 2.
// - Degas request honoured only while the selected filament is on.
// - Sensitivity held, adjustable 2 to 99, preloaded with factory value.
// - At most one of two filaments operated; select defaults to first.
// - Low below high: energize under low, de-energize above high.
// - Low above high: energize above low, de-energize below high.
// - Setpoints accepted only within 1.00E-11 to 3.00E-02 Torr.
// - Low setpoint starts at 1.00E-06, high at 5.00E-06 Torr.
// - Relay test mode, default off, toggles relay overriding comparison.
// - Ion-only analog mode: 0 to 9 V, 1 V per decade.
// - Combined mode: merged pressure, 0.5 to 7 V, 0.5 V per decade.
// - Four hour totals readable, all zero at start.
`ifndef IGSR_PARAMS_SVH
`define IGSR_PARAMS_SVH
// Register byte offsets
`define IGSR_CTRL 8'h00
`define IGSR_DEGAS_MIN 8'h04
`define IGSR_SENS 8'h08
`define IGSR_LO_SP 8'h0C
`define IGSR_HI_SP 8'h10
`define IGSR_STATUS 8'h14
`define IGSR_HOURS0 8'h18
`define IGSR_DEGAS_LEFT 8'h28
// Control field positions
`define IGSR_B_FILSEL 0
`define IGSR_B_TEST 1
`define IGSR_B_COMB 2
`define IGSR_B_TOGGLE 3
// Pressure code: (exponent + 12) * 1000 + mantissa * 100
`define IGSR_SP_MIN 16'h044C
`define IGSR_SP_MAX 16'h283C
`define IGSR_LO_RST 16'h17D4
`define IGSR_HI_RST 16'h1964
`define IGSR_CONV_SWITCH 16'h2454
// Degas minutes and sensitivity limits
`define IGSR_DMIN_LO 4'h2
`define IGSR_DMIN_HI 4'hA
`define IGSR_SENS_LO 7'h02
`define IGSR_SENS_HI 7'h63
// Analog scaling in millivolts
`define IGSR_ION_MAX_MV 14'h2328
`define IGSR_COMB_MIN_MV 14'h01F4
`define IGSR_COMB_MAX_MV 14'h1B58
// Timing
`define IGSR_CLK_HZ 64'd25000000
`define IGSR_MINUTE_S 64'd60
`define IGSR_HOUR_S 64'd3600
`define IGSR_CYC_MIN (`IGSR_CLK_HZ * `IGSR_MINUTE_S)
`define IGSR_CYC_HOUR (`IGSR_CLK_HZ * `IGSR_HOUR_S)
`endif

// >>> igsr_pkg.sv
// Types for the ion gauge setpoint relay control block
package igsr_pkg;
    typedef logic [15:0] igsr_press_t;
    typedef enum logic [1:0] {
        IGSR_DG_IDLE = 2'b00,
        IGSR_DG_RUN = 2'b01
    } igsr_degas_e;
endpackage

// >>> igsr_top.sv
// Ion gauge degas timer, setpoint relay, analog scaling and hour logs
`timescale 1ns/1ps
`include "igsr_params.svh"
module igsr_top
    import igsr_pkg::*;
#(
    parameter logic [31:0] CYC_PER_MIN = 32'(`IGSR_CYC_MIN),
    parameter logic [39:0] CYC_PER_HOUR = 40'(`IGSR_CYC_HOUR),
    parameter logic [6:0] FACTORY_SENS = 7'h0A, // arbitrary sensor value
    parameter int HOUR_W = 20,
    parameter logic [4:0] ION_ZERO_DEC = 5'h02, // 0 V decade index
    parameter logic [4:0] COMB_ZERO_DEC = 5'h02
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Gauge inputs
    input wire logic i_fil_on,
    input wire logic i_degas_req,
    input wire logic i_degas_stop,
    input wire logic [15:0] i_ion_press,
    input wire logic [15:0] i_conv_press,
    // Filament, degas and sensitivity outputs
    output logic o_fil1_drive,
    output logic o_fil2_drive,
    output logic o_degas,
    output logic [6:0] o_sensitivity,
    // Relay and analog output
    output logic o_relay,
    output logic [13:0] o_analog_mv
);
    // Elaboration checks
    if (CYC_PER_MIN < 32'd2 || CYC_PER_HOUR < 40'd2) begin : g_bad_cnt
        $error("igsr_top: count parameters too small");
    end
    if (HOUR_W < 1 || HOUR_W > 32) begin : g_bad_w
        $error("igsr_top: HOUR_W must be 1 to 32");
    end
    // Setpoint range check
    function automatic logic sp_ok(input logic [15:0] v);
        return v >= `IGSR_SP_MIN && v <= `IGSR_SP_MAX;
    endfunction

    // Log10 of mantissa leading digit, in millidecades
    function automatic logic [9:0] frac_md(input logic [9:0] m);
        logic [3:0] d;
        d = 4'(m / 10'd100);
        case (d)
            4'h2: return 10'h12D;
            4'h3: return 10'h1DD;
            4'h4: return 10'h25A;
            4'h5: return 10'h2BB;
            4'h6: return 10'h30A;
            4'h7: return 10'h34D;
            4'h8: return 10'h387;
            4'h9: return 10'h3BA;
            default: return 10'h000;
        endcase
    endfunction

    // Pressure code to millidecades above a zero decade
    function automatic logic [15:0] md_above(input logic [15:0] p,
                                             input logic [4:0] z);
        logic [4:0] dec;
        logic [9:0] man;
        dec = 5'(p / 16'd1000);
        man = 10'(p % 16'd1000);
        if (dec < z) begin
            return 16'h0000;
        end
        return 16'(16'(dec - z) * 16'd1000) + 16'(frac_md(man));
    endfunction

    logic fil_sel_r;
    logic test_en_r;
    logic comb_r;
    logic test_state_r;
    logic [3:0] degas_min_r;
    logic [6:0] sens_r;
    logic [15:0] lo_sp_r;
    logic [15:0] hi_sp_r;
    logic cmp_r;
    igsr_degas_e dg_st_r;
    logic [31:0] dg_cyc_r;
    logic [3:0] dg_left_r;
    logic [39:0] pre_r [4];
    logic [HOUR_W-1:0] hours_r [4];
    logic [31:0] rdata_r;
    logic wr_ctrl;
    logic dg_wrap;
    assign wr_ctrl = i_wr && i_addr == `IGSR_CTRL;
    // Control bits
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            fil_sel_r <= 1'b0;
            test_en_r <= 1'b0;
            comb_r <= 1'b0;
        end else if (wr_ctrl) begin
            fil_sel_r <= i_wdata[`IGSR_B_FILSEL];
            test_en_r <= i_wdata[`IGSR_B_TEST];
            comb_r <= i_wdata[`IGSR_B_COMB];
        end
    end

    // Test relay state, toggled on command
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            test_state_r <= 1'b0;
        end else if (!test_en_r) begin
            test_state_r <= cmp_r;
        end else if (wr_ctrl && i_wdata[`IGSR_B_TOGGLE]) begin
            test_state_r <= !test_state_r;
        end
    end

    // Degas minutes, out of range writes ignored
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            degas_min_r <= `IGSR_DMIN_LO;
        end else if (i_wr && i_addr == `IGSR_DEGAS_MIN
                     && i_wdata[31:0] >= 32'(`IGSR_DMIN_LO)
                     && i_wdata[31:0] <= 32'(`IGSR_DMIN_HI)) begin
            degas_min_r <= i_wdata[3:0];
        end
    end

    // Sensitivity
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            sens_r <= FACTORY_SENS;
        end else if (i_wr && i_addr == `IGSR_SENS
                     && i_wdata >= 32'(`IGSR_SENS_LO)
                     && i_wdata <= 32'(`IGSR_SENS_HI)) begin
            sens_r <= i_wdata[6:0];
        end
    end

    // Setpoints, accepted only in range
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            lo_sp_r <= `IGSR_LO_RST;
            hi_sp_r <= `IGSR_HI_RST;
        end else if (i_wr && i_wdata[31:16] == 16'h0000
                     && sp_ok(i_wdata[15:0])) begin
            if (i_addr == `IGSR_LO_SP) begin
                lo_sp_r <= i_wdata[15:0];
            end
            if (i_addr == `IGSR_HI_SP) begin
                hi_sp_r <= i_wdata[15:0];
            end
        end
    end

    // Setpoint comparator with hysteresis
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            cmp_r <= 1'b0;
        end else if (lo_sp_r > hi_sp_r) begin
            if (i_ion_press > lo_sp_r) begin
                cmp_r <= 1'b1;
            end else if (i_ion_press < hi_sp_r) begin
                cmp_r <= 1'b0;
            end
        end else begin
            if (i_ion_press < lo_sp_r) begin
                cmp_r <= 1'b1;
            end else if (i_ion_press > hi_sp_r) begin
                cmp_r <= 1'b0;
            end
        end
        // Between setpoints nothing changes
    end

    // Relay output, test mode overrides
    assign o_relay = test_en_r ? test_state_r : cmp_r;

    // Degas timer
    assign dg_wrap = dg_cyc_r == CYC_PER_MIN - 32'd1;
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            dg_st_r <= IGSR_DG_IDLE;
            dg_cyc_r <= 32'd0;
            dg_left_r <= 4'h0;
        end else begin
            case (dg_st_r)
                IGSR_DG_IDLE: begin
                    if (i_degas_req && i_fil_on) begin
                        dg_st_r <= IGSR_DG_RUN;
                        dg_cyc_r <= 32'd0;
                        dg_left_r <= degas_min_r;
                    end
                end
                IGSR_DG_RUN: begin
                    if (!i_fil_on || i_degas_stop) begin
                        dg_st_r <= IGSR_DG_IDLE;
                        dg_left_r <= 4'h0;
                    end else if (dg_wrap) begin
                        dg_cyc_r <= 32'd0;
                        dg_left_r <= dg_left_r - 4'h1;
                        if (dg_left_r == 4'h1) begin
                            dg_st_r <= IGSR_DG_IDLE;
                        end
                    end else begin
                        dg_cyc_r <= dg_cyc_r + 32'd1;
                    end
                end
                default: begin
                    dg_st_r <= IGSR_DG_IDLE;
                end
            endcase
        end
    end
    assign o_degas = dg_st_r == IGSR_DG_RUN;

    // One filament at a time
    assign o_fil1_drive = i_fil_on && !fil_sel_r;
    assign o_fil2_drive = i_fil_on && fil_sel_r;
    assign o_sensitivity = sens_r;

    // Hour logs: 0,1 on-time, 2,3 degas time, per filament
    always_ff @(posedge i_core_clk) begin
        for (int k = 0; k < 4; k++) begin
            if (i_rst) begin
                pre_r[k] <= 40'd0;
                hours_r[k] <= '0;
            end else if ((k < 2 ? i_fil_on : o_degas)
                         && fil_sel_r == k[0]) begin
                if (pre_r[k] == CYC_PER_HOUR - 40'd1) begin
                    pre_r[k] <= 40'd0;
                    hours_r[k] <= hours_r[k] + 1'b1;
                end else begin
                    pre_r[k] <= pre_r[k] + 40'd1;
                end
            end
        end
    end

    // Analog output scaling
    always_ff @(posedge i_core_clk) begin
        logic [15:0] md;
        logic [15:0] mv;
        md = 16'h0000;
        mv = 16'h0000;
        if (i_rst) begin
            o_analog_mv <= 14'h0000;
        end else if (comb_r) begin
            if (!i_fil_on || i_conv_press >= `IGSR_CONV_SWITCH) begin
                md = md_above(i_conv_press, COMB_ZERO_DEC);
            end else begin
                md = md_above(i_ion_press, COMB_ZERO_DEC);
            end
            mv = 16'(`IGSR_COMB_MIN_MV) + (md >> 1);
            o_analog_mv <= mv > 16'(`IGSR_COMB_MAX_MV)
                ? `IGSR_COMB_MAX_MV : mv[13:0];
        end else begin
            md = md_above(i_ion_press, ION_ZERO_DEC);
            o_analog_mv <= md > 16'(`IGSR_ION_MAX_MV)
                ? `IGSR_ION_MAX_MV : md[13:0];
        end
    end

    // Read data, valid the cycle after the strobe
    always_ff @(posedge i_core_clk) begin
        if (i_rst || !i_rd) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            case (i_addr)
                `IGSR_CTRL: rdata_r <= {29'h0, comb_r, test_en_r, fil_sel_r};
                `IGSR_DEGAS_MIN: rdata_r <= {28'h0, degas_min_r};
                `IGSR_SENS: rdata_r <= {25'h0, sens_r};
                `IGSR_LO_SP: rdata_r <= {16'h0, lo_sp_r};
                `IGSR_HI_SP: rdata_r <= {16'h0, hi_sp_r};
                `IGSR_STATUS: rdata_r <= {27'h0, i_fil_on, test_state_r,
                                          o_degas, cmp_r, o_relay};
                8'h18: rdata_r <= 32'(hours_r[0]);
                8'h1C: rdata_r <= 32'(hours_r[1]);
                8'h20: rdata_r <= 32'(hours_r[2]);
                8'h24: rdata_r <= 32'(hours_r[3]);
                `IGSR_DEGAS_LEFT: rdata_r <= {28'h0, dg_left_r};
                default: rdata_r <= 32'h0000_0000;
            endcase
        end
    end
    assign o_rdata = rdata_r;
    // Checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    property p_degas_gate;
        $rose(o_degas) |-> $past(i_fil_on) && $past(i_degas_req);
    endproperty
    a_degas_gate: assert property (p_degas_gate)
        else $error("degas started without filament on");
    property p_degas_drop;
        o_degas && !i_fil_on |=> !o_degas;
    endproperty
    a_degas_drop: assert property (p_degas_drop)
        else $error("degas kept after filament off");
    property p_degas_end;
        $fell(o_degas) && $past(i_fil_on) && !$past(i_degas_stop)
            |-> $past(dg_left_r) == 4'h1 && $past(dg_wrap);
    endproperty
    a_degas_end: assert property (p_degas_end)
        else $error("degas ended early");
    property p_degas_load;
        $rose(o_degas) |-> dg_left_r == $past(degas_min_r)
            && dg_left_r >= `IGSR_DMIN_LO && dg_left_r <= `IGSR_DMIN_HI;
    endproperty
    a_degas_load: assert property (p_degas_load)
        else $error("degas minutes wrong");
    property p_sens_range;
        sens_r >= `IGSR_SENS_LO && sens_r <= `IGSR_SENS_HI;
    endproperty
    a_sens_range: assert property (p_sens_range)
        else $error("sensitivity out of range");
    property p_sp_range;
        sp_ok(lo_sp_r) && sp_ok(hi_sp_r);
    endproperty
    a_sp_range: assert property (p_sp_range)
        else $error("setpoint out of range");
    property p_one_fil;
        !(o_fil1_drive && o_fil2_drive);
    endproperty
    a_one_fil: assert property (p_one_fil)
        else $error("both filaments driven");
    property p_rly_norm;
        !test_en_r && lo_sp_r < hi_sp_r && i_ion_press < lo_sp_r
            ##1 !test_en_r |-> o_relay;
    endproperty
    a_rly_norm: assert property (p_rly_norm)
        else $error("relay not energized below low setpoint");
    property p_rly_inv;
        !test_en_r && lo_sp_r > hi_sp_r && i_ion_press < hi_sp_r
            ##1 !test_en_r |-> !o_relay;
    endproperty
    a_rly_inv: assert property (p_rly_inv)
        else $error("inverted relay not released below high");
    property p_rly_hold;
        (i_ion_press >= lo_sp_r && i_ion_press <= hi_sp_r)
            || (i_ion_press >= hi_sp_r && i_ion_press <= lo_sp_r)
            |=> cmp_r == $past(cmp_r);
    endproperty
    a_rly_hold: assert property (p_rly_hold)
        else $error("relay changed between setpoints");
    property p_test_toggle;
        test_en_r && wr_ctrl && i_wdata[`IGSR_B_TEST]
            && i_wdata[`IGSR_B_TOGGLE] |=> o_relay != $past(o_relay);
    endproperty
    a_test_toggle: assert property (p_test_toggle)
        else $error("test toggle had no effect");
    property p_comb_span;
        comb_r && $past(comb_r) |-> o_analog_mv >= `IGSR_COMB_MIN_MV
            && o_analog_mv <= `IGSR_COMB_MAX_MV;
    endproperty
    a_comb_span: assert property (p_comb_span)
        else $error("combined analog out of span");
    property p_hour_mono;
        hours_r[0] != $past(hours_r[0]) |-> $past(i_fil_on)
            && !$past(fil_sel_r) && $past(pre_r[0]) == CYC_PER_HOUR - 40'd1;
    endproperty
    a_hour_mono: assert property (p_hour_mono)
        else $error("hour log advanced without a full hour");
endmodule // igsr_top

// >>> igsr_relay_wiring.sv
// Relay contact and analog meter model for the setpoint relay block
`timescale 1ns/1ps
module igsr_relay_wiring (
    // Clock
    input wire logic i_core_clk,
    // Design outputs seen by the wiring
    input wire logic i_relay,
    input wire logic [13:0] i_analog_mv,
    // Contact and meter readings
    output logic o_contact_no,
    output logic o_contact_nc,
    output logic [13:0] o_meter_mv
);
    // Changeover contact follows the coil
    assign o_contact_no = i_relay;
    assign o_contact_nc = ~i_relay;
    // Meter samples the analog level each clock
    always_ff @(posedge i_core_clk) begin
        o_meter_mv <= i_analog_mv;
    end
endmodule // igsr_relay_wiring

// >>> igsr_top_bench.sv
// Self-checking bench for the ion gauge setpoint relay block
`timescale 1ns/1ps
`include "igsr_params.svh"
`define TB_CHK(a, b) begin \
    checks_done++; \
    if ((a) !== (b)) begin \
        err_total++; \
        $display("Error at %0t: got %h expected %h", $time, a, b); \
    end \
end
module igsr_top_bench;
    localparam logic [6:0] SENS0 = 7'h0A; // arbitrary sensor value
    localparam int MIN_CYC = 10;
    // Design connections
    logic i_core_clk, i_rst, i_wr, i_rd, i_fil_on, i_degas_req, i_degas_stop;
    logic [7:0] i_addr;
    logic [31:0] i_wdata, o_rdata;
    logic [15:0] i_ion_press, i_conv_press;
    logic o_fil1_drive, o_fil2_drive, o_degas, o_relay, contact_nc;
    logic [6:0] o_sensitivity;
    logic [13:0] o_analog_mv, meter_mv;
    int err_total, checks_done, cyc_count, n;
    // One row: settings, pressures and expected relay and analog level
    typedef struct {
        logic [7:0] ctrl;
        logic [15:0] lo, hi, ion, conv;
        logic relay;
        logic [13:0] mv;
    } igsr_row_s;
    igsr_row_s rows [11];

    igsr_top #(.CYC_PER_MIN(32'(MIN_CYC)), .CYC_PER_HOUR(40'd20),
        .FACTORY_SENS(SENS0)) u_igsr_top (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_fil_on(i_fil_on), .i_degas_req(i_degas_req),
        .i_degas_stop(i_degas_stop), .i_ion_press(i_ion_press),
        .i_conv_press(i_conv_press), .o_fil1_drive(o_fil1_drive),
        .o_fil2_drive(o_fil2_drive), .o_degas(o_degas),
        .o_sensitivity(o_sensitivity), .o_relay(o_relay),
        .o_analog_mv(o_analog_mv));
    igsr_relay_wiring u_igsr_relay_wiring (.i_core_clk(i_core_clk),
        .i_relay(o_relay), .i_analog_mv(o_analog_mv), .o_contact_no(),
        .o_contact_nc(contact_nc), .o_meter_mv(meter_mv));

    // Clock and hang guard
    always #20 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) begin
        cyc_count++;
        if (cyc_count == 3000) begin
            err_total++;
            results();
        end
    end

    task automatic results();
        $display("Checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic do_reset();
        @(posedge i_core_clk);
        i_rst <= 1'b1;
        repeat (8) @(posedge i_core_clk);
        i_rst <= 1'b0;
    endtask
    task automatic wait_cyc(input int c);
        repeat (c) @(posedge i_core_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        `TB_CHK(o_rdata, e)
    endtask
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, e);
        wr(a, d);
        rd_chk(a, e);
    endtask
    task automatic ctrl_relay(input logic [31:0] d, input logic e);
        wr(`IGSR_CTRL, d);
        wait_cyc(2);
        `TB_CHK(o_relay, e)
    endtask
    // Pulses a degas request and counts cycles with degas active
    task automatic degas_len(output int c);
        @(posedge i_core_clk);
        i_degas_req <= 1'b1;
        @(posedge i_core_clk);
        i_degas_req <= 1'b0;
        c = 0;
        repeat (40) begin
            #1;
            if (o_degas === 1'b1) c++;
            @(posedge i_core_clk);
        end
    endtask

    // Main sequence
    initial begin
        {i_core_clk, i_wr, i_rd, i_fil_on, i_degas_req, i_degas_stop} = '0;
        i_rst = 1'b1;
        i_addr = 8'h00;
        i_wdata = 32'h0;
        i_ion_press = 16'h1900;
        i_conv_press = 16'h0000;
        {err_total, checks_done, cyc_count} = '0;
        rows = '{'{8'h0, 16'h13EC, 16'h1BBC, 16'h17D4, 16'h0, 0, 14'h0FA0},
            '{8'h0, 16'h13EC, 16'h1BBC, 16'h1004, 16'h0, 1, 14'h07D0},
            '{8'h0, 16'h13EC, 16'h1BBC, 16'h17D4, 16'h0, 1, 14'h0FA0},
            '{8'h0, 16'h13EC, 16'h1BBC, 16'h1FA4, 16'h0, 0, 14'h1770},
            '{8'h0, 16'h1BBC, 16'h13EC, 16'h1FA4, 16'h0, 1, 14'h1770},
            '{8'h0, 16'h1BBC, 16'h13EC, 16'h17D4, 16'h0, 1, 14'h0FA0},
            '{8'h0, 16'h1BBC, 16'h13EC, 16'h044C, 16'h0, 0, 14'h0000},
            '{8'h4, 16'h1BBC, 16'h13EC, 16'h17D4, 16'h0, 0, 14'h09C4},
            '{8'h4, 16'h1BBC, 16'h13EC, 16'h17D4, 16'h2774, 0, 14'h1194},
            '{8'h0, 16'h1BBC, 16'h13EC, 16'h076C, 16'h0, 0, 14'h0000},
            '{8'h0, 16'h1BBC, 16'h13EC, 16'h2F44, 16'h0, 1, 14'h2328}};
        do_reset();
        i_fil_on <= 1'b1;
        wait_cyc(1);
        `TB_CHK(o_fil1_drive, 1'b1)
        `TB_CHK(o_fil2_drive, 1'b0)
        `TB_CHK(o_sensitivity, SENS0)
        `TB_CHK(o_relay, 1'b0)
        rd_chk(`IGSR_DEGAS_MIN, 32'h2);
        rd_chk(`IGSR_LO_SP, 32'h17D4);
        rd_chk(`IGSR_HI_SP, 32'h1964);
        for (int i = 0; i < 4; i++)
            rd_chk(8'(`IGSR_HOURS0 + 4 * i), 32'h0);
        rd_chk(8'h3C, 32'h0);
        // Boundaries of the adjustable settings
        wr_rd(`IGSR_SENS, 32'h01, 32'h0A);
        wr_rd(`IGSR_SENS, 32'h64, 32'h0A);
        wr_rd(`IGSR_SENS, 32'h63, 32'h63);
        wr_rd(`IGSR_SENS, 32'h02, 32'h02);
        `TB_CHK(o_sensitivity, 7'h02)
        wr_rd(`IGSR_DEGAS_MIN, 32'h1, 32'h2);
        wr_rd(`IGSR_DEGAS_MIN, 32'hB, 32'h2);
        wr_rd(`IGSR_DEGAS_MIN, 32'hA, 32'hA);
        wr_rd(`IGSR_LO_SP, 32'h044B, 32'h17D4);
        wr_rd(`IGSR_LO_SP, 32'h044C, 32'h044C);
        wr_rd(`IGSR_HI_SP, 32'h283D, 32'h1964);
        wr_rd(`IGSR_HI_SP, 32'h1283C, 32'h1964);
        wr_rd(`IGSR_HI_SP, 32'h283C, 32'h283C);
        wr(`IGSR_CTRL, 32'h1);
        wait_cyc(1);
        `TB_CHK(o_fil1_drive, 1'b0)
        `TB_CHK(o_fil2_drive, 1'b1)
        // Ordinary cases
        foreach (rows[i]) begin
            wr(`IGSR_CTRL, {24'h0, rows[i].ctrl});
            wr(`IGSR_LO_SP, {16'h0, rows[i].lo});
            wr(`IGSR_HI_SP, {16'h0, rows[i].hi});
            i_ion_press <= rows[i].ion;
            i_conv_press <= rows[i].conv;
            wait_cyc(3);
            `TB_CHK(o_relay, rows[i].relay)
            `TB_CHK(contact_nc, ~rows[i].relay)
            `TB_CHK(o_analog_mv, rows[i].mv)
            `TB_CHK(meter_mv, rows[i].mv)
        end
        // Relay test override against a comparison that stays energized
        ctrl_relay(32'h02, 1'b1);
        ctrl_relay(32'h0A, 1'b0);
        ctrl_relay(32'h0A, 1'b1);
        ctrl_relay(32'h0A, 1'b0);
        ctrl_relay(32'h00, 1'b1);
        // Degas refused with filament off
        i_fil_on <= 1'b0;
        degas_len(n);
        `TB_CHK(n, 0)
        // Second reset, then degas length and hour totals
        i_fil_on <= 1'b1;
        do_reset();
        `TB_CHK(o_sensitivity, SENS0)
        `TB_CHK(o_relay, 1'b0)
        wr(`IGSR_DEGAS_MIN, 32'h3);
        degas_len(n);
        `TB_CHK(n, 3 * MIN_CYC)
        i_fil_on <= 1'b0;
        rd_chk(`IGSR_HOURS0, 32'h2);
        rd_chk(8'(`IGSR_HOURS0 + 8), 32'h1);
        wr(`IGSR_CTRL, 32'h1);
        i_fil_on <= 1'b1;
        wait_cyc(25);
        i_fil_on <= 1'b0;
        rd_chk(8'(`IGSR_HOURS0 + 4), 32'h1);
        rd_chk(8'(`IGSR_HOURS0 + 12), 32'h0);
        // Degas aborted part way
        i_fil_on <= 1'b1;
        @(posedge i_core_clk);
        i_degas_req <= 1'b1;
        @(posedge i_core_clk);
        i_degas_req <= 1'b0;
        wait_cyc(5);
        `TB_CHK(o_degas, 1'b1)
        rd_chk(`IGSR_DEGAS_LEFT, 32'h3);
        @(posedge i_core_clk);
        i_degas_stop <= 1'b1;
        wait_cyc(2);
        `TB_CHK(o_degas, 1'b0)
        // Filament on, relay released above the high setpoint
        rd_chk(`IGSR_STATUS, 32'h10);
        results();
    end
endmodule // igsr_top_bench
